// ### verilog/flash_guard_map.svh
// Offsets, field positions, reset values and fixed figures of the flash
// guard and command register slice. Definitions only.
`ifndef FLASH_GUARD_MAP_SVH
`define FLASH_GUARD_MAP_SVH

// Byte offsets on the register port.
`define FG_OFS_INDEX      8'h01
`define FG_OFS_STATUS     8'h06
`define FG_OFS_GUARD      8'h09
`define FG_OFS_CMD_HI     8'h0a
`define FG_OFS_CMD_LO     8'h0b
`define FG_OFS_RSV1       8'h0c
`define FG_OFS_RSV2       8'h0d
`define FG_OFS_RSV3       8'h0e
`define FG_OFS_RSV4       8'h0f
`define FG_OFS_OPTION     8'h10
`define FG_OFS_RSV5       8'h11
`define FG_OFS_RSV6       8'h12
`define FG_OFS_RSV7       8'h13

// Field positions.
`define FG_GUARD_OPEN_BIT 7
`define FG_STAT_DONE_BIT  7
`define FG_STAT_VIOL_BIT  5

// Reset values and fault fallbacks.
`define FG_GUARD_SECURE   8'h0f
`define FG_OPTION_FAULT   8'hff
`define FG_GUARD_RSV_MASK 8'h8f

// Command array and protected range.
`define FG_CMD_WORDS      6
`define FG_GUARD_BASE     18'h04400
`define FG_GUARD_STEP     8
`define FG_CFG_GUARD_ADR  18'h3ff0d
`define FG_CFG_OPTION_ADR 18'h3ff0e

`endif

// ### verilog/flash_guard_pkg.sv
// Types shared by the flash guard and command register slice.
// Does not use the map header; every figure the types carry is written as a literal.
package flash_guard_pkg;

   typedef logic [15:0]      cmd_word_t;
   typedef cmd_word_t [5:0]  cmd_block_t;

   // Bytes fetched from the configuration field during the reset sequence.
   typedef struct packed {
      logic [7:0] guard_byte;
      logic       guard_fault;
      logic [7:0] option_byte;
      logic       option_fault;
   } cfg_load_t;

   // Program or erase request checked against the data-flash guard.
   typedef struct packed {
      logic        block_erase;
      logic [17:0] addr;
   } pe_req_t;

   // Result word written back by the memory controller.
   typedef struct packed {
      logic [2:0] idx;
      cmd_word_t  data;
   } result_t;

endpackage

// ### verilog/flash_guard_regs.sv
// Register slice of the flash controller: data-flash guard, indexed command
// array, option register and the reserved factory-test registers.
// Assumes one 10 MHz clock, a synchronous active-high reset, a byte-wide
// register port and a memory controller on the same clock.
//
// Local design decisions: the address map and the strobed register port.

`timescale 1ns/100ps
`include "flash_guard_map.svh"

module flash_guard_regs
   import flash_guard_pkg::*;
(
   input  wire logic       i_clk,        // 10 MHz clock
   input  wire logic       i_rst,        // synchronous reset, high
   input  wire logic [7:0] i_addr,       // register byte offset
   input  wire logic [7:0] i_wdata,      // register write data
   input  wire logic       i_wr,         // write strobe
   input  wire logic       i_rd,         // read strobe
   output logic      [7:0] o_rdata,      // read data, cycle after strobe
   input  wire logic       i_cfg_load,   // configuration bytes are valid
   input  wire cfg_load_t  i_cfg,        // configuration field contents
   output logic            o_cmd_start,  // command launched, one cycle
   output cmd_block_t      o_cmd,        // command words to controller
   input  wire logic       i_cmd_done,   // controller finished command
   input  wire logic       i_res_we,     // controller writes a result
   input  wire result_t    i_res,        // result index and word
   input  wire logic       i_pe_chk,     // program or erase check request
   input  wire pe_req_t    i_pe,         // address and kind of operation
   output logic            o_pe_refuse,  // check answer, cycle after
   output logic            o_guard_on    // data-flash guard active
);

   logic [7:0]  guard_q;
   logic [7:0]  option_q;
   logic [2:0]  index_q;
   logic        done_q;
   logic        viol_q;
   logic        start_q;
   logic        refuse_q;
   logic [7:0]  rdata_q;
   logic [15:0] cmd_q [`FG_CMD_WORDS];

   logic        wr_index;
   logic        wr_status;
   logic        wr_guard;
   logic        wr_cmd_hi;
   logic        wr_cmd_lo;
   logic        launch;
   logic        guard_open;
   logic [3:0]  guard_size;
   logic [18:0] guard_end;
   logic        in_range;
   logic        refuse_d;
   logic [7:0]  rdata_d;
   cmd_word_t   cur_word;

   assign wr_index  = i_wr && (i_addr == `FG_OFS_INDEX);
   assign wr_status = i_wr && (i_addr == `FG_OFS_STATUS);
   assign wr_guard  = i_wr && (i_addr == `FG_OFS_GUARD);
   assign wr_cmd_hi = i_wr && (i_addr == `FG_OFS_CMD_HI);
   assign wr_cmd_lo = i_wr && (i_addr == `FG_OFS_CMD_LO);

   assign guard_open = guard_q[`FG_GUARD_OPEN_BIT];
   assign guard_size = guard_q[3:0];

   assign launch = wr_status && i_wdata[`FG_STAT_DONE_BIT] && done_q &&
                   !i_cmd_done;

   // Guard register. A configuration load overrides software, because it
   // only happens inside the reset sequence before code runs.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         guard_q <= `FG_GUARD_SECURE;
      end else if (i_cfg_load) begin
         if (i_cfg.guard_fault) begin
            guard_q <= `FG_GUARD_SECURE;
         end else begin
            guard_q <= i_cfg.guard_byte & `FG_GUARD_RSV_MASK;
         end
      end else if (wr_guard) begin
         guard_q[`FG_GUARD_OPEN_BIT] <= guard_open &
                                        i_wdata[`FG_GUARD_OPEN_BIT];
         if (i_wdata[3:0] > guard_size) begin
            guard_q[3:0] <= i_wdata[3:0];
         end
         // bits 6 to 4 stay zero
         guard_q[6:4] <= 3'h0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         option_q <= `FG_OPTION_FAULT;
      end else if (i_cfg_load) begin
         option_q <= i_cfg.option_fault ? `FG_OPTION_FAULT
                                        : i_cfg.option_byte;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         index_q <= 3'h0;
      end else if (wr_index) begin
         index_q <= i_wdata[2:0];
      end
   end

   // Completion flag. A completion in the same cycle as a launching write
   // wins and the write is dropped, so no start pulse leaves with the flag
   // still set.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         done_q <= 1'b1;
      end else if (i_cmd_done) begin
         done_q <= 1'b1;
      end else if (launch) begin
         done_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         start_q <= 1'b0;
      end else begin
         start_q <= launch;
      end
   end

   // Violation flag is cleared by writing one; a new refusal in the same
   // cycle keeps it set so no event is lost.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         viol_q <= 1'b0;
      end else if (refuse_d) begin
         viol_q <= 1'b1;
      end else if (wr_status && i_wdata[`FG_STAT_VIOL_BIT]) begin
         viol_q <= 1'b0;
      end
   end

   assign guard_end = {1'b0, `FG_GUARD_BASE} +
                      19'({guard_size + 5'h01, 8'h00});
   assign in_range  = ({1'b0, i_pe.addr} >= {1'b0, `FG_GUARD_BASE}) &&
                      ({1'b0, i_pe.addr} < guard_end);

   always_comb begin
      refuse_d = 1'b0;
      if (i_pe_chk && !guard_open) begin
         if (i_pe.block_erase) begin
            refuse_d = 1'b1;
         end else if (in_range) begin
            refuse_d = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         refuse_q <= 1'b0;
      end else begin
         refuse_q <= refuse_d;
      end
   end

   // One process per command word; software bytes and controller results
   // share the word but are never allowed at the same time.
   generate
      for (genvar g = 0; g < `FG_CMD_WORDS; g++) begin : g_word
         localparam logic [2:0] IDX = 3'(g);
         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               cmd_q[g] <= 16'h0000;
            end else if (!done_q) begin
               if (i_res_we && (i_res.idx == IDX)) begin
                  cmd_q[g] <= i_res.data;
               end
            end else if (index_q == IDX) begin
               if (wr_cmd_hi) begin
                  cmd_q[g][15:8] <= i_wdata;
               end
               if (wr_cmd_lo) begin
                  cmd_q[g][7:0] <= i_wdata;
               end
            end
         end
         assign o_cmd[g] = cmd_q[g];
      end
   endgenerate

   assign cur_word = (index_q < 3'(`FG_CMD_WORDS)) ? cmd_q[index_q]
                                                   : 16'h0000;

   always_comb begin
      rdata_d = 8'h00;
      unique case (i_addr)
         `FG_OFS_INDEX:  rdata_d = {5'h00, index_q};
         `FG_OFS_STATUS: begin
            rdata_d[`FG_STAT_DONE_BIT] = done_q;
            rdata_d[`FG_STAT_VIOL_BIT] = viol_q;
         end
         `FG_OFS_GUARD:  rdata_d = guard_q;
         `FG_OFS_CMD_HI: rdata_d = cur_word[15:8];
         `FG_OFS_CMD_LO: rdata_d = cur_word[7:0];
         `FG_OFS_OPTION: rdata_d = option_q;
         default:        rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rdata_q <= 8'h00;
      end else if (i_rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign o_rdata     = rdata_q;
   assign o_cmd_start = start_q;
   assign o_pe_refuse = refuse_q;
   assign o_guard_on  = !guard_open;

   // Checks on the behaviour above.
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   logic [95:0] cmd_flat;
   assign cmd_flat = o_cmd;

   sequence launch_s;
      wr_status && i_wdata[`FG_STAT_DONE_BIT] && done_q && !i_cmd_done;
   endsequence

   sequence start_pulse_s;
      o_cmd_start && !done_q ##1 !o_cmd_start;
   endsequence

   sequence reserved_read_s;
      i_rd && ((i_addr >= `FG_OFS_RSV1 && i_addr <= `FG_OFS_RSV4) ||
               (i_addr >= `FG_OFS_RSV5 && i_addr <= `FG_OFS_RSV7));
   endsequence

   a_size_only_grows: assert property (
      wr_guard && !i_cfg_load && (i_wdata[3:0] <= guard_size)
      |=> $stable(guard_size))
      else $error("guard size changed on a non-enlarging write");

   a_open_never_reopens: assert property (
      !guard_open && !i_cfg_load |=> !guard_open)
      else $error("guard open bit went from 0 to 1");

   a_open_ignores_size: assert property (
      i_pe_chk && guard_open |=> !o_pe_refuse)
      else $error("refusal while guard open");

   a_cfg_guard_load: assert property (
      i_cfg_load && !i_cfg.guard_fault
      |=> guard_q == ($past(i_cfg.guard_byte) & `FG_GUARD_RSV_MASK))
      else $error("guard register not loaded from stored byte");

   a_guard_fault_full: assert property (
      i_cfg_load && i_cfg.guard_fault
      |=> !guard_open && guard_size == 4'hf)
      else $error("guard fault did not leave data flash protected");

   a_refuse_sets_viol: assert property (
      o_pe_refuse |-> viol_q)
      else $error("refusal without violation flag");

   a_block_erase_refused: assert property (
      i_pe_chk && i_pe.block_erase && !guard_open |=> o_pe_refuse)
      else $error("block erase allowed while protected");

   a_range_edge: assert property (
      i_pe_chk && !i_pe.block_erase && !guard_open
      |=> o_pe_refuse == ($past(i_pe.addr) >= `FG_GUARD_BASE &&
          {1'b0, $past(i_pe.addr)} <
          {1'b0, `FG_GUARD_BASE} +
          19'({$past(guard_size) + 5'h01, 8'h00})))
      else $error("protected range boundary wrong");

   a_launch_clears_flag: assert property (
      launch_s |=> start_pulse_s)
      else $error("launch did not clear flag with one start pulse");

   a_done_wins: assert property (
      i_cmd_done |=> done_q && !o_cmd_start)
      else $error("launch taken in the cycle of a completion");

   a_busy_no_launch: assert property (
      wr_status && i_wdata[`FG_STAT_DONE_BIT] && !done_q |=> !o_cmd_start)
      else $error("launch accepted while command busy");

   a_byte_write_hi: assert property (
      wr_cmd_hi && done_q && index_q < 3'h6
      |=> o_cmd[$past(index_q)][15:8] == $past(i_wdata))
      else $error("high byte write not placed in indexed word");

   a_result_placed: assert property (
      !done_q && i_res_we && i_res.idx < 3'h6
      |=> o_cmd[$past(i_res.idx)] == $past(i_res.data))
      else $error("result word not placed in array");

   a_array_locked: assert property (
      !done_q && !i_res_we |=> $stable(cmd_flat))
      else $error("command array changed while busy");

   a_unused_index_zero: assert property (
      i_rd && (i_addr == `FG_OFS_CMD_HI || i_addr == `FG_OFS_CMD_LO) &&
      index_q >= 3'h6 |=> o_rdata == 8'h00)
      else $error("unused index did not read zero");

   a_reserved_zero: assert property (
      reserved_read_s |=> o_rdata == 8'h00)
      else $error("reserved register read nonzero");

   a_option_read_only: assert property (
      !i_cfg_load |=> $stable(option_q))
      else $error("option register changed without a load");

   a_option_load: assert property (
      i_cfg_load && !i_cfg.option_fault
      |=> option_q == $past(i_cfg.option_byte))
      else $error("option register not loaded from stored byte");

   a_option_fault_ones: assert property (
      i_cfg_load && i_cfg.option_fault |=> option_q == 8'hff)
      else $error("option fault did not set all bits");

   a_guard_rsv_zero: assert property (
      guard_q[6:4] == 3'h0)
      else $error("guard bits 6 to 4 not zero");

endmodule // flash_guard_regs

// ### bench/flash_guard_regs_test.sv
// Self-checking bench for the flash guard and command register slice.
// Assumes the map header and package are compiled first, one 10 MHz clock.
`timescale 1ns/100ps
`include "flash_guard_map.svh"

module flash_guard_regs_test;
   import flash_guard_pkg::*;

   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic [7:0]  i_addr = 8'h00;
   logic [7:0]  i_wdata = 8'h00;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic        i_cfg_load = 1'b0;
   cfg_load_t   i_cfg = '0;
   logic        i_cmd_done = 1'b0;
   logic        i_res_we = 1'b0;
   result_t     i_res = '0;
   logic        i_pe_chk = 1'b0;
   pe_req_t     i_pe = '0;
   logic [7:0]  o_rdata;
   logic        o_cmd_start;
   cmd_block_t  o_cmd;
   logic        o_pe_refuse;
   logic        o_guard_on;
   int          num_errors = 0;
   int          checked = 0;
   int          cycles = 0;
   logic [15:0] rq[$];
   logic        pq[$];
   logic        sq[$];
   logic        rd_d = 1'b0;
   logic        pe_d = 1'b0;
   logic        st_d = 1'b0;
   logic [15:0] e;
   logic [15:0] arr[8];
   logic [7:0]  hb;
   logic [7:0]  lb;
   logic [17:0] a;
   logic [17:0] pa[5] = '{18'h043ff, 18'h04400, 18'h04bff, 18'h04c00,
                          18'h05000};
   logic        pr[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
   logic [7:0]  rsv[7] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h11, 8'h12, 8'h13};

   always #50 i_clk = ~i_clk;

   flash_guard_regs u_flash_guard_regs (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_addr      (i_addr),
      .i_wdata     (i_wdata),
      .i_wr        (i_wr),
      .i_rd        (i_rd),
      .o_rdata     (o_rdata),
      .i_cfg_load  (i_cfg_load),
      .i_cfg       (i_cfg),
      .o_cmd_start (o_cmd_start),
      .o_cmd       (o_cmd),
      .i_cmd_done  (i_cmd_done),
      .i_res_we    (i_res_we),
      .i_res       (i_res),
      .i_pe_chk    (i_pe_chk),
      .i_pe        (i_pe),
      .o_pe_refuse (o_pe_refuse),
      .o_guard_on  (o_guard_on)
   );

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Every pulse input is set exactly once per cycle, so none is doubled.
   task automatic cyc(input logic w, r, p, d, s, c);
      i_wr <= w;
      i_rd <= r;
      i_pe_chk <= p;
      i_cmd_done <= d;
      i_res_we <= s;
      i_cfg_load <= c;
      @(posedge i_clk);
   endtask

   task automatic idle();
      cyc(0, 0, 0, 0, 0, 0);
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      i_addr <= ad;
      i_wdata <= d;
      cyc(1, 0, 0, 0, 0, 0);
   endtask

   task automatic rd(input logic [7:0] ad, input logic [7:0] x,
                     input logic [7:0] m = 8'hff);
      i_addr <= ad;
      rq.push_back({m, x});
      cyc(0, 1, 0, 0, 0, 0);
   endtask

   task automatic pe(input logic [17:0] ad, input logic be, input logic x);
      i_pe <= {be, ad};
      pq.push_back(x);
      cyc(0, 0, 1, 0, 0, 0);
   endtask

   task automatic cfg(input logic [7:0] g, input logic gf,
                      input logic [7:0] o, input logic of);
      i_cfg <= {g, gf, o, of};
      cyc(0, 0, 0, 0, 0, 1);
   endtask

   task automatic launch(input logic x);
      i_addr <= `FG_OFS_STATUS;
      i_wdata <= 8'h80;
      sq.push_back(x);
      cyc(1, 0, 0, 0, 0, 0);
   endtask

   // Results are looked at in the one cycle where they stand.
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (rd_d) begin
         e = rq.pop_front();
         chk({8'h00, o_rdata & e[15:8]}, {8'h00, e[7:0]});
      end
      if (pe_d)
         chk({15'h0, o_pe_refuse}, {15'h0, pq.pop_front()});
      if (st_d)
         chk({15'h0, o_cmd_start}, {15'h0, sq.pop_front()});
      rd_d <= i_rd;
      pe_d <= i_pe_chk;
      st_d <= i_wr && i_addr == `FG_OFS_STATUS && i_wdata[7];
      if (cycles == 5000) begin
         num_errors++;
         conclude();
      end
   end

   initial begin
      void'($urandom(32'h4ce1c6bd));
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(`FG_OFS_GUARD, `FG_GUARD_SECURE); // secure until loaded
      rd(`FG_OFS_OPTION, `FG_OPTION_FAULT); // all set until loaded
      rd(`FG_OFS_STATUS, 8'h80, 8'ha0); // idle flag
      $display("test reset done");
      cfg(8'hf3, 1'b0, 8'h5a, 1'b0);
      rd(`FG_OFS_GUARD, 8'h83); // loaded byte
      rd(`FG_OFS_OPTION, 8'h5a); // loaded byte
      idle();
      chk({15'h0, o_guard_on}, 16'h0); // open means off
      pe(18'h04400, 1'b0, 1'b0); // open ignores size
      pe(18'h04400, 1'b1, 1'b0); // erase allowed open
      wr(`FG_OFS_GUARD, 8'h82);
      rd(`FG_OFS_GUARD, 8'h83); // shrink ignored
      wr(`FG_OFS_GUARD, 8'hf5);
      rd(`FG_OFS_GUARD, 8'h85); // grow taken
      wr(`FG_OFS_GUARD, 8'h07);
      rd(`FG_OFS_GUARD, 8'h07); // close taken
      wr(`FG_OFS_GUARD, 8'h87);
      rd(`FG_OFS_GUARD, 8'h07); // reopen refused
      idle();
      chk({15'h0, o_guard_on}, 16'h1); // guard active
      $display("test guard writes done");
      for (int k = 0; k < 5; k++)
         pe(pa[k], 1'b0, pr[k]); // range edges
      pe(18'h3ff00, 1'b1, 1'b1); // block erase refused
      for (int k = 0; k < 8; k++) begin
         a = 18'h04400 + 18'($urandom % 4096);
         pe(a, 1'b0, a < 18'h04c00); // random address
      end
      rd(`FG_OFS_STATUS, 8'h20, 8'h20); // violation flagged
      wr(`FG_OFS_STATUS, 8'h20);
      rd(`FG_OFS_STATUS, 8'h00, 8'h20); // flag cleared
      $display("test guard range done");
      cfg(8'h80, 1'b1, 8'h00, 1'b1);
      rd(`FG_OFS_GUARD, `FG_GUARD_SECURE); // fault fallback
      rd(`FG_OFS_OPTION, 8'hff); // fault fallback
      wr(`FG_OFS_OPTION, 8'h00);
      rd(`FG_OFS_OPTION, 8'hff); // write ignored
      for (int k = 0; k < 7; k++) begin
         wr(rsv[k], 8'hff);
         rd(rsv[k], 8'h00); // reads zero
      end
      rd(8'h20, 8'h00);
      $display("test option reserved done");
      for (int k = 0; k < 8; k++) begin
         hb = 8'($urandom);
         lb = 8'($urandom);
         wr(`FG_OFS_INDEX, 8'(k));
         wr(`FG_OFS_CMD_HI, hb);
         wr(`FG_OFS_CMD_LO, lb);
         arr[k] = (k < 6) ? {hb, lb} : 16'h0000;
      end
      for (int k = 0; k < 8; k++) begin
         wr(`FG_OFS_INDEX, 8'(k));
         rd(`FG_OFS_CMD_HI, arr[k][15:8]); // high byte
         rd(`FG_OFS_CMD_LO, arr[k][7:0]); // low byte
      end
      idle();
      for (int k = 0; k < 6; k++)
         chk(o_cmd[k], arr[k]); // words to controller
      $display("test command array done");
      launch(1'b1); // launch pulse
      rd(`FG_OFS_STATUS, 8'h00, 8'h80); // flag cleared
      wr(`FG_OFS_INDEX, 8'h01);
      wr(`FG_OFS_CMD_HI, ~arr[1][15:8]);
      rd(`FG_OFS_CMD_HI, arr[1][15:8]); // locked
      launch(1'b0); // busy launch ignored
      i_res <= {3'd2, 16'($urandom)};
      cyc(0, 0, 0, 0, 1, 0);
      arr[2] = i_res.data;
      cyc(0, 0, 0, 1, 0, 0);
      rd(`FG_OFS_STATUS, 8'h80, 8'h80); // flag returned
      wr(`FG_OFS_INDEX, 8'h02);
      rd(`FG_OFS_CMD_HI, arr[2][15:8]); // result high
      rd(`FG_OFS_CMD_LO, arr[2][7:0]); // result low
      idle();
      chk(o_cmd[1], arr[1]); // word unchanged
      i_addr <= `FG_OFS_STATUS;
      i_wdata <= 8'h80;
      sq.push_back(1'b0);
      cyc(1, 0, 0, 1, 0, 0); // completion wins
      rd(`FG_OFS_STATUS, 8'h80, 8'h80); // flag stays set
      repeat (3) idle();
      $display("test launch done");
      i_rst <= 1'b1;
      repeat (2) idle();
      i_rst <= 1'b0;
      rd(`FG_OFS_GUARD, `FG_GUARD_SECURE); // secure after reset
      rd(`FG_OFS_INDEX, 8'h00); // index cleared
      rd(`FG_OFS_STATUS, 8'h80, 8'ha0); // idle flag again
      repeat (2) idle();
      $display("test second reset done");
      conclude();
   end
endmodule // flash_guard_regs_test
